//--- hdl/lmie_consts.svh
// Purpose: Constants for the literal, move and indirect-store execution unit
// Assumes: 14-bit instruction words of the enhanced mid-range core
// Notes: Opcode patterns and masks, widths, reset values
`ifndef LMIE_CONSTS_SVH
`define LMIE_CONSTS_SVH

// ==========================================================================
// Opcode match patterns and masks
`define LMIE_OP_IDLE 14'h0000
`define LMIE_OP_RESET 14'h0001
`define LMIE_OP_OPTION 14'h0062
`define LMIE_MASK_FULL 14'h3FFF
`define LMIE_OP_BANK 14'h0020
`define LMIE_MASK_BANK 14'h3FE0
`define LMIE_OP_PAGE 14'h3180
`define LMIE_MASK_PAGE 14'h3F80
`define LMIE_OP_LITW 14'h3000
`define LMIE_MASK_LITW 14'h3F00
`define LMIE_OP_STFILE 14'h0080
`define LMIE_MASK_STFILE 14'h3F80
`define LMIE_OP_IND 14'h0018
`define LMIE_MASK_IND 14'h3FF8
`define LMIE_OP_IND_OFS 14'h3F80
`define LMIE_MASK_IND_OFS 14'h3F80

// ==========================================================================
// Field positions
`define LMIE_BANK_MSB 4
`define LMIE_PCH_MSB 6
`define LMIE_K8_MSB 7
`define LMIE_F_MSB 6
`define LMIE_IND_IDX_BIT 2
`define LMIE_IND_IDX_OFS_BIT 6
`define LMIE_OFS_MSB 5

// ==========================================================================
// Widths and reset values
`define LMIE_BANK_USED 4'hF
`define LMIE_PTR_ONE 16'h0001
`define LMIE_RST_ACC 8'h00
`define LMIE_RST_BANK 5'h00
`define LMIE_RST_PCH 7'h00
`define LMIE_RST_OPT 8'hFF
`define LMIE_RST_PTR 16'h0000
`define LMIE_PULSE_CYC 2'h3
`define LMIE_ZERO2 2'h0
`endif

//--- hdl/lmie_pkg.sv
// Purpose: Types shared by the execution unit files
// Assumes: lmie_consts.svh supplies the numbers
// Notes: One-hot enum for the instruction class
package lmie_pkg;
  typedef enum logic [8:0] {
    LMIE_I_IDLE = 9'h001,
    LMIE_I_BANK = 9'h002,
    LMIE_I_PCH = 9'h004,
    LMIE_I_LIT = 9'h008,
    LMIE_I_STF = 9'h010,
    LMIE_I_IND = 9'h020,
    LMIE_I_OFS = 9'h040,
    LMIE_I_OPT = 9'h080,
    LMIE_I_RST = 9'h100
  } lmie_instr_e;
  typedef enum logic [1:0] {
    LMIE_M_PREINC = 2'h0,
    LMIE_M_PREDEC = 2'h1,
    LMIE_M_POSTINC = 2'h2,
    LMIE_M_POSTDEC = 2'h3
  } lmie_mode_e;
endpackage

//--- hdl/lmie_decode.sv
// Purpose: Classify one instruction word of the execution unit
// Assumes: Word is stable while valid is high
// Notes: Pure combinational; unknown words fall back to no-op
`timescale 1ns/1ps
`include "lmie_consts.svh"
module lmie_decode (
  input wire logic [13:0] word_in,
  output lmie_pkg::lmie_instr_e class_out
);
  import lmie_pkg::*;

  function automatic logic hit(input logic [13:0] w, input logic [13:0] op, input logic [13:0] m);
    hit = ((w & m) == op);
  endfunction

  // ========================================================================
  // Priority decode, most specific pattern first
  always_comb begin
    if (hit(word_in, `LMIE_OP_RESET, `LMIE_MASK_FULL)) begin
      class_out = LMIE_I_RST;
    end else if (hit(word_in, `LMIE_OP_OPTION, `LMIE_MASK_FULL)) begin
      class_out = LMIE_I_OPT;
    end else if (hit(word_in, `LMIE_OP_IND, `LMIE_MASK_IND)) begin
      class_out = LMIE_I_IND;
    end else if (hit(word_in, `LMIE_OP_BANK, `LMIE_MASK_BANK)) begin
      class_out = LMIE_I_BANK;
    end else if (hit(word_in, `LMIE_OP_STFILE, `LMIE_MASK_STFILE)) begin
      class_out = LMIE_I_STF;
    end else if (hit(word_in, `LMIE_OP_IND_OFS, `LMIE_MASK_IND_OFS)) begin
      class_out = LMIE_I_OFS;
    end else if (hit(word_in, `LMIE_OP_PAGE, `LMIE_MASK_PAGE)) begin
      class_out = LMIE_I_PCH;
    end else if (hit(word_in, `LMIE_OP_LITW, `LMIE_MASK_LITW)) begin
      class_out = LMIE_I_LIT;
    end else begin
      class_out = LMIE_I_IDLE;
    end
  end
endmodule

//--- hdl/lmie_ptr_mem.sv
// Purpose: Holds the two 16-bit pointer registers
// Assumes: One write port, registered read of both pointers
// Notes: Read data reflect the last write one cycle later
`timescale 1ns/1ps
`include "lmie_consts.svh"
module lmie_ptr_mem (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic wr_idx_in,
  input wire logic [15:0] wr_data_in,
  output logic [15:0] ptr0_out,
  output logic [15:0] ptr1_out
);
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ptr0_out <= `LMIE_RST_PTR;
      ptr1_out <= `LMIE_RST_PTR;
    end else if (wr_en_in) begin
      if (wr_idx_in) begin
        ptr1_out <= wr_data_in;
      end else begin
        ptr0_out <= wr_data_in;
      end
    end
  end
endmodule

//--- hdl/lmie_exec.sv
// Purpose: Executes literal loads, accumulator stores, indirect stores,
//          option load, no-op and software restart of an 8-bit core
// Assumes: One instruction word per clock when instr_valid_in is high
// Notes: Status flags live elsewhere; this unit never drives a flag update
`timescale 1ns/1ps
`include "lmie_consts.svh"
module lmie_exec (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic instr_valid_in,
  input wire logic [13:0] instr_in,
  input wire logic restart_flag_set_in,
  output logic [7:0] accum_out,
  output logic [4:0] bank_select_reg_out,
  output logic [6:0] pc_high_latch_out,
  output logic [7:0] option_reg_out,
  output logic [15:0] pointer_reg_0_out,
  output logic [15:0] pointer_reg_1_out,
  output logic mem_wr_out,
  output logic [15:0] mem_addr_out,
  output logic [7:0] mem_data_out,
  output logic file_wr_out,
  output logic [6:0] file_addr_out,
  output logic sw_restart_flag_n_out,
  output logic sw_reset_req_out,
  output logic flags_wr_out
);
  import lmie_pkg::*;

  // ========================================================================
  // Reset release
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ========================================================================
  // State
  typedef struct packed {
    logic [7:0] accum;
    logic [4:0] bank;
    logic [6:0] pch;
    logic [7:0] opt;
    logic mem_wr;
    logic [15:0] mem_addr;
    logic [7:0] mem_data;
    logic file_wr;
    logic [6:0] file_addr;
    logic restart_n;
    logic [1:0] rst_cnt;
  } lmie_state_s;

  lmie_state_s st;
  lmie_state_s next_st;
  lmie_instr_e cls;
  logic ptr_wr;
  logic ptr_idx;
  logic [15:0] next_ptr;
  logic [15:0] ptr0;
  logic [15:0] ptr1;

  function automatic logic [15:0] sext_ofs(input logic [5:0] k);
    sext_ofs = {{10{k[`LMIE_OFS_MSB]}}, k};
  endfunction

  lmie_decode u_dec (
    .word_in(instr_in),
    .class_out(cls)
  );

  lmie_ptr_mem u_ptr (
    .clk_in(clk_in),
    .rst_n_in(rst_sync),
    .wr_en_in(ptr_wr),
    .wr_idx_in(ptr_idx),
    .wr_data_in(next_ptr),
    .ptr0_out(ptr0),
    .ptr1_out(ptr1)
  );

  // ========================================================================
  // Execute
  always_comb begin
    logic [15:0] cur;
    logic [15:0] adj;
    cur = `LMIE_RST_PTR;
    adj = `LMIE_RST_PTR;
    next_st = st;
    next_st.mem_wr = 1'b0;
    next_st.file_wr = 1'b0;
    ptr_wr = 1'b0;
    ptr_idx = 1'b0;
    next_ptr = `LMIE_RST_PTR;
    if (restart_flag_set_in) begin
      next_st.restart_n = 1'b1;
    end
    if (st.rst_cnt != `LMIE_ZERO2) begin
      next_st.rst_cnt = st.rst_cnt - 2'h1;
    end
    if (instr_valid_in && st.rst_cnt == `LMIE_ZERO2) begin
      case (cls)
        LMIE_I_BANK: begin
          next_st.bank = {1'b0, instr_in[3:0] & `LMIE_BANK_USED};
        end
        LMIE_I_PCH: begin
          next_st.pch = instr_in[`LMIE_PCH_MSB:0];
        end
        LMIE_I_LIT: begin
          next_st.accum = instr_in[`LMIE_K8_MSB:0];
        end
        LMIE_I_STF: begin
          next_st.file_wr = 1'b1;
          next_st.file_addr = instr_in[`LMIE_F_MSB:0];
          next_st.mem_data = st.accum;
        end
        LMIE_I_IND: begin
          ptr_idx = instr_in[`LMIE_IND_IDX_BIT];
          cur = ptr_idx ? ptr1 : ptr0;
          // Plain 16-bit add wraps on its own; no carry escapes
          case (lmie_mode_e'(instr_in[1:0]))
            LMIE_M_PREINC, LMIE_M_POSTINC: adj = cur + `LMIE_PTR_ONE;
            default: adj = cur - `LMIE_PTR_ONE;
          endcase
          ptr_wr = 1'b1;
          next_ptr = adj;
          next_st.mem_wr = 1'b1;
          next_st.mem_data = st.accum;
          next_st.mem_addr = instr_in[1] ? cur : adj;
        end
        LMIE_I_OFS: begin
          ptr_idx = instr_in[`LMIE_IND_IDX_OFS_BIT];
          cur = ptr_idx ? ptr1 : ptr0;
          next_st.mem_wr = 1'b1;
          next_st.mem_data = st.accum;
          next_st.mem_addr = cur + sext_ofs(instr_in[`LMIE_OFS_MSB:0]);
        end
        LMIE_I_OPT: begin
          next_st.opt = st.accum;
        end
        LMIE_I_RST: begin
          next_st.restart_n = 1'b0;
          next_st.rst_cnt = `LMIE_PULSE_CYC;
        end
        LMIE_I_IDLE: begin
          next_st = next_st;
        end
        default: begin
          next_st = next_st;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_sync) begin
    if (!rst_sync) begin
      st.accum <= `LMIE_RST_ACC;
      st.bank <= `LMIE_RST_BANK;
      st.pch <= `LMIE_RST_PCH;
      st.opt <= `LMIE_RST_OPT;
      st.mem_wr <= 1'b0;
      st.mem_addr <= `LMIE_RST_PTR;
      st.mem_data <= `LMIE_RST_ACC;
      st.file_wr <= 1'b0;
      st.file_addr <= `LMIE_RST_PCH;
      st.restart_n <= 1'b1;
      st.rst_cnt <= `LMIE_ZERO2;
    end else begin
      st <= next_st;
    end
  end

  // ========================================================================
  // Outputs
  assign accum_out = st.accum;
  assign bank_select_reg_out = st.bank;
  assign pc_high_latch_out = st.pch;
  assign option_reg_out = st.opt;
  assign pointer_reg_0_out = ptr0;
  assign pointer_reg_1_out = ptr1;
  assign mem_wr_out = st.mem_wr;
  assign mem_addr_out = st.mem_addr;
  assign mem_data_out = st.mem_data;
  assign file_wr_out = st.file_wr;
  assign file_addr_out = st.file_addr;
  assign sw_restart_flag_n_out = st.restart_n;
  // Reset request held a few cycles so slow reset logic sees it
  assign sw_reset_req_out = (st.rst_cnt != `LMIE_ZERO2);
  assign flags_wr_out = 1'b0;

  // ========================================================================
  // Checks
  lit_load_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_LIT && !sw_reset_req_out) |=> accum_out == $past(instr_in[7:0]))
    else $error("accumulator literal not loaded");
  bank_load_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_BANK && !sw_reset_req_out) |=> bank_select_reg_out == {1'b0, $past(instr_in[3:0])})
    else $error("bank select not loaded");
  page_load_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_PCH && !sw_reset_req_out) |=> pc_high_latch_out == $past(instr_in[6:0]))
    else $error("page latch not loaded");
  file_store_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_STF && !sw_reset_req_out)
      |=> file_wr_out && file_addr_out == $past(instr_in[6:0]) && mem_data_out == $past(accum_out))
    else $error("file store wrong");
  ofs_store_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_OFS && !sw_reset_req_out)
      |=> mem_wr_out && $stable(pointer_reg_0_out) && $stable(pointer_reg_1_out))
    else $error("offset store moved a pointer");
  preinc_addr_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IND && instr_in[1:0] == 2'h0 && !instr_in[2] && !sw_reset_req_out)
      |=> mem_addr_out == pointer_reg_0_out && pointer_reg_0_out == $past(pointer_reg_0_out) + 16'h0001)
    else $error("preincrement address wrong");
  postdec_addr_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IND && instr_in[1:0] == 2'h3 && instr_in[2] && !sw_reset_req_out)
      |=> mem_addr_out == $past(pointer_reg_1_out) && pointer_reg_1_out == $past(pointer_reg_1_out) - 16'h0001)
    else $error("postdecrement wrong");
  opt_load_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_OPT && !sw_reset_req_out) |=> option_reg_out == $past(accum_out))
    else $error("option not loaded");
  sw_restart_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_RST && !sw_reset_req_out && !restart_flag_set_in)
      |=> !sw_restart_flag_n_out ##0 sw_reset_req_out [*3])
    else $error("restart not signalled");
  nop_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IDLE && !sw_reset_req_out)
      |=> $stable(accum_out) && !mem_wr_out && !file_wr_out && $stable(option_reg_out))
    else $error("no-op changed state");
  no_flags_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    mem_wr_out |-> !flags_wr_out)
    else $error("flag write during store");
  predec_addr_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IND && instr_in[1:0] == 2'h1 && !instr_in[2] && !sw_reset_req_out)
      |=> mem_addr_out == pointer_reg_0_out && pointer_reg_0_out == $past(pointer_reg_0_out) - 16'h0001)
    else $error("predecrement wrong");
  postinc_addr_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IND && instr_in[1:0] == 2'h2 && instr_in[2] && !sw_reset_req_out)
      |=> mem_addr_out == $past(pointer_reg_1_out) && pointer_reg_1_out == $past(pointer_reg_1_out) + 16'h0001)
    else $error("postincrement wrong");
  ind_data_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IND && !sw_reset_req_out)
      |=> mem_wr_out && !file_wr_out && mem_data_out == $past(accum_out))
    else $error("indirect store data wrong");
  ofs_addr_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_OFS && !instr_in[6] && !sw_reset_req_out)
      |=> mem_addr_out == $past(pointer_reg_0_out) + {{10{$past(instr_in[5])}}, $past(instr_in[5:0])}
        && mem_data_out == $past(accum_out))
    else $error("offset store address wrong");
  ind_other0_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IND && !instr_in[2] && !sw_reset_req_out)
      |=> $stable(pointer_reg_1_out))
    else $error("unselected pointer moved");
  ind_other1_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_IND && instr_in[2] && !sw_reset_req_out)
      |=> $stable(pointer_reg_0_out))
    else $error("unselected pointer moved");
  stf_no_mem_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_STF && !sw_reset_req_out)
      |=> !mem_wr_out && $stable(pointer_reg_0_out) && $stable(pointer_reg_1_out))
    else $error("file store touched memory port");
  lit_quiet_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_LIT && !sw_reset_req_out)
      |=> !mem_wr_out && !file_wr_out && $stable(option_reg_out) && $stable(pointer_reg_0_out))
    else $error("literal load had side effects");
  opt_keeps_acc_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_OPT && !sw_reset_req_out)
      |=> $stable(accum_out) && !mem_wr_out && !file_wr_out)
    else $error("option load had side effects");
  restart_ignore_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && sw_reset_req_out)
      |=> $stable(accum_out) && $stable(bank_select_reg_out) && $stable(pc_high_latch_out)
        && $stable(option_reg_out) && !mem_wr_out && !file_wr_out)
    else $error("instruction taken during restart");
  clear_wins_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_RST && !sw_reset_req_out)
      |=> !sw_restart_flag_n_out)
    else $error("restart flag not cleared");
  flag_set_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (restart_flag_set_in && !(instr_valid_in && cls == LMIE_I_RST && !sw_reset_req_out))
      |=> sw_restart_flag_n_out)
    else $error("restart flag not set");
  restart_len_a: assert property (@(posedge clk_in) disable iff (!rst_sync)
    (instr_valid_in && cls == LMIE_I_RST && !sw_reset_req_out)
      |=> ##3 !sw_reset_req_out)
    else $error("restart request too long");
endmodule

//--- sim/literal_move_indirect_exec_bench.sv
// Purpose: Self-checking bench for the literal, move and indirect-store execution unit
// Assumes: Results show just after the taking edge; strobes last one cycle
// Notes: Pointer values are tracked in the bench, starting from reset and updated per indirect store
`timescale 1ns/1ps

`define CHK(act, exp) begin samples_checked++; if ((act) !== (exp)) begin fail_count++; \
  $display("Error at %0t: value mismatch", $time); end end

module literal_move_indirect_exec_bench;
  logic clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic instr_valid_in = 1'b0;
  logic [13:0] instr_in = 14'h0000;
  logic restart_flag_set_in = 1'b0;
  logic [7:0] accum_out;
  logic [4:0] bank_select_reg_out;
  logic [6:0] pc_high_latch_out;
  logic [7:0] option_reg_out;
  logic [15:0] pointer_reg_0_out;
  logic [15:0] pointer_reg_1_out;
  logic mem_wr_out;
  logic [15:0] mem_addr_out;
  logic [7:0] mem_data_out;
  logic file_wr_out;
  logic [6:0] file_addr_out;
  logic sw_restart_flag_n_out;
  logic sw_reset_req_out;
  logic flags_wr_out;
  int fail_count = 0;
  int samples_checked = 0;
  logic [7:0] acc;
  logic [15:0] p [2];

  always #10 clk_in = ~clk_in;

  lmie_exec dut (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .instr_valid_in(instr_valid_in), .instr_in(instr_in),
    .restart_flag_set_in(restart_flag_set_in), .accum_out(accum_out),
    .bank_select_reg_out(bank_select_reg_out), .pc_high_latch_out(pc_high_latch_out),
    .option_reg_out(option_reg_out), .pointer_reg_0_out(pointer_reg_0_out),
    .pointer_reg_1_out(pointer_reg_1_out), .mem_wr_out(mem_wr_out), .mem_addr_out(mem_addr_out),
    .mem_data_out(mem_data_out), .file_wr_out(file_wr_out), .file_addr_out(file_addr_out),
    .sw_restart_flag_n_out(sw_restart_flag_n_out), .sw_reset_req_out(sw_reset_req_out),
    .flags_wr_out(flags_wr_out)
  );

  // ==========================================================================
  // Drivers
  task issue(input logic [13:0] w);
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= w;
  endtask

  task idle();
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
  endtask

  // Ends just after the edge that takes the word, so its results are settled
  task run(input logic [13:0] w);
    issue(w);
    idle();
    #1;
  endtask

  task set_w(input logic [7:0] k);
    run(14'h3000 | {6'h00, k});
    acc = k;
  endtask

  task end_sim();
    $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task t_reset();
    `CHK(accum_out, 8'h00);
    `CHK(bank_select_reg_out, 5'h00);
    `CHK(pc_high_latch_out, 7'h00);
    `CHK(option_reg_out, 8'hFF);
    `CHK({pointer_reg_0_out, pointer_reg_1_out}, 32'h00000000);
    `CHK({mem_wr_out, file_wr_out, sw_reset_req_out}, 3'h0);
    `CHK(sw_restart_flag_n_out, 1'b1);
  endtask

  task t_literals();
    logic [7:0] v [3];
    v = '{8'h00, 8'hFF, 8'h5A};
    foreach (v[i]) begin
      run(14'h0020 | {10'h000, v[i][3:0]});
      `CHK(bank_select_reg_out, {1'b0, v[i][3:0]});
      run(14'h3180 | {7'h00, v[i][6:0]});
      `CHK(pc_high_latch_out, v[i][6:0]);
      set_w(v[i]);
      `CHK(accum_out, v[i]);
      `CHK(flags_wr_out, 1'b0);
    end
    run(14'h003F);
    `CHK(bank_select_reg_out, 5'h0F);
    // Back to back: each load completes in its own single cycle
    issue(14'h0027);
    issue(14'h3191);
    #1;
    `CHK(bank_select_reg_out, 5'h07);
    idle();
    #1;
    `CHK(pc_high_latch_out, 7'h11);
  endtask

  task t_store_file();
    logic [6:0] f [2];
    f = '{7'h00, 7'h7F};
    set_w(8'h4F);
    foreach (f[i]) begin
      run(14'h0080 | {7'h00, f[i]});
      `CHK({file_wr_out, mem_wr_out, file_addr_out, mem_data_out}, {2'b10, f[i], 8'h4F});
      @(posedge clk_in);
      #1;
      `CHK(file_wr_out, 1'b0);
    end
  endtask

  task t_indirect();
    logic [1:0] m [4];
    logic [1:0] mode_sel;
    logic [15:0] a;
    m = '{2'h1, 2'h2, 2'h0, 2'h3};
    for (int n = 0; n < 2; n++) begin
      set_w(8'hA0 + 8'(n));
      foreach (m[i]) begin
        mode_sel = m[i];
        a = mode_sel[1] ? p[n] : (mode_sel[0] ? p[n] - 16'h0001 : p[n] + 16'h0001);
        run(14'h0018 | {11'h000, n[0], mode_sel});
        p[n] = mode_sel[0] ? p[n] - 16'h0001 : p[n] + 16'h0001;
        `CHK({mem_wr_out, file_wr_out, mem_data_out}, {2'b10, acc});
        `CHK(mem_addr_out, a);
        `CHK({pointer_reg_0_out, pointer_reg_1_out}, {p[0], p[1]});
        `CHK(flags_wr_out, 1'b0);
      end
    end
    // Back to back preincrements: the second sees the first one's pointer
    issue(14'h0018);
    issue(14'h0018);
    #1;
    `CHK(mem_addr_out, p[0] + 16'h0001);
    idle();
    #1;
    p[0] = p[0] + 16'h0002;
    `CHK({mem_wr_out, mem_addr_out, pointer_reg_0_out}, {1'b1, p[0], p[0]});
  endtask

  task t_offset();
    logic [5:0] k [3];
    m_loop: for (int n = 0; n < 2; n++) begin
      k = '{6'h1F, 6'h20, 6'h00};
      foreach (k[i]) begin
        run(14'h3F80 | {7'h00, n[0], k[i]});
        `CHK({mem_wr_out, mem_data_out}, {1'b1, acc});
        `CHK(mem_addr_out, p[n] + {{10{k[i][5]}}, k[i]});
        `CHK({pointer_reg_0_out, pointer_reg_1_out}, {p[0], p[1]});
      end
    end
  endtask

  task t_option_nop();
    logic [60:0] snap;
    set_w(8'h4F);
    run(14'h0062);
    `CHK(option_reg_out, 8'h4F);
    snap = {accum_out, bank_select_reg_out, pc_high_latch_out, option_reg_out, pointer_reg_0_out,
      pointer_reg_1_out, sw_restart_flag_n_out};
    run(14'h0000);
    `CHK({accum_out, bank_select_reg_out, pc_high_latch_out, option_reg_out, pointer_reg_0_out,
      pointer_reg_1_out, sw_restart_flag_n_out}, snap);
    `CHK({mem_wr_out, file_wr_out, flags_wr_out}, 3'h0);
  endtask

  task t_restart();
    issue(14'h0001);
    // Taken while the restart request is active, so it must be ignored
    issue(14'h3077);
    #1;
    `CHK({sw_restart_flag_n_out, sw_reset_req_out}, 2'b01);
    idle();
    #1;
    `CHK(sw_reset_req_out, 1'b1);
    @(posedge clk_in);
    #1;
    `CHK(sw_reset_req_out, 1'b1);
    @(posedge clk_in);
    #1;
    `CHK({sw_reset_req_out, accum_out}, {1'b0, acc});
    @(posedge clk_in);
    restart_flag_set_in <= 1'b1;
    @(posedge clk_in);
    restart_flag_set_in <= 1'b0;
    #1;
    `CHK(sw_restart_flag_n_out, 1'b1);
    // Set and restart in one cycle: the clear must win
    @(posedge clk_in);
    instr_valid_in <= 1'b1;
    instr_in <= 14'h0001;
    restart_flag_set_in <= 1'b1;
    @(posedge clk_in);
    instr_valid_in <= 1'b0;
    restart_flag_set_in <= 1'b0;
    #1;
    `CHK({sw_restart_flag_n_out, sw_reset_req_out}, 2'b01);
    repeat (3) @(posedge clk_in);
    #1;
    `CHK({sw_restart_flag_n_out, sw_reset_req_out}, 2'b00);
  endtask

  // ==========================================================================
  // Sequence
  initial begin
    p[0] = 16'h0000;
    p[1] = 16'h0000;
    acc = 8'h00;
    repeat (12) @(posedge clk_in);
    rst_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    #1;
    t_reset();
    t_literals();
    t_store_file();
    t_indirect();
    t_offset();
    t_option_nop();
    t_restart();
    end_sim();
  end

  // A hang anywhere above ends the run as a mismatch
  initial begin
    #500000;
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    end_sim();
  end
endmodule
